//--- lldp_datapath.sv
// lldp_datapath.sv: datapath of a low latency dram controller
// assumes: command logic on CLOCK; memory pins are registered here
//
// Overview of operation
// - read data returned twice memory width
// - write data/mask registers load only when valid
// - data drivers enabled only during write
// - one read valid flag per device
// - zero bus always, one bus optional
// - built for 100 to 400 MHz clock
// - read bits grouped per strobe: 8,9,16,18
// - strobe mode uses return strobe, else ignored
`timescale 1ns/1ns
`include "lldp_regs.svh"
module lldp_datapath
    import lldp_pkg::*;
#(
    parameter int DATA_W   = 18,
    parameter int ADDR_W   = 20,
    parameter int DEVICES  = 1,
    parameter int GROUP    = 9,
    parameter int SPLIT_IO = 0,
    parameter int TWO_CMD  = 0,
    parameter int CLK_MHZ  = `LLDP_CLK_MHZ_DEF,
    parameter int STROBES  = DATA_W / GROUP
)
(
    input  wire logic                             CLOCK,
    input  wire logic                             RSTN,
    input  wire logic                             STROBE_MODE,
    input  wire logic [ADDR_W-1:0]                CTL_ADDR,
    input  wire logic [`LLDP_BANK_W-1:0]          CTL_BANK,
    input  wire logic                             CTL_CS_N,
    input  wire logic                             CTL_WE_N,
    input  wire logic                             CTL_REF_N,
    input  wire logic                             CTL_DOING_WR,
    input  wire logic [2*DATA_W-1:0]              CTL_WDATA,
    input  wire logic                             CTL_WDATA_VALID,
    input  wire logic [`LLDP_MASK_PER_DEV*DEVICES-1:0] CTL_WRITE_MASK,
    output logic      [2*DATA_W-1:0]              CTL_RDATA,
    output logic      [DEVICES-1:0]               CTL_QVLD,
    output logic      [ADDR_W-1:0]                MEM_ADDR_0,
    output logic      [`LLDP_BANK_W-1:0]          MEM_BANK_0,
    output logic                                  MEM_CS_N_0,
    output logic                                  MEM_WE_N_0,
    output logic                                  MEM_REF_N_0,
    output logic      [ADDR_W-1:0]                MEM_ADDR_1,
    output logic      [`LLDP_BANK_W-1:0]          MEM_BANK_1,
    output logic                                  MEM_CS_N_1,
    output logic                                  MEM_WE_N_1,
    output logic                                  MEM_REF_N_1,
    output logic      [DATA_W-1:0]                MEM_DQ_O,
    output logic      [DATA_W-1:0]                MEM_DQ_OE_N,
    input  wire logic [DATA_W-1:0]                MEM_DQ_I,
    output logic      [DATA_W-1:0]                MEM_D,
    output logic                                  MEM_D_OE_N,
    input  wire logic [DATA_W-1:0]                MEM_Q,
    input  wire logic [STROBES-1:0]               MEM_RETURN_STROBE,
    input  wire logic [DEVICES-1:0]               MEM_QVLD,
    output logic      [DEVICES-1:0]               MEM_BYTE_MASK
);
    localparam int DEV_W = DATA_W / DEVICES;

    // ----------------------------------------------------------------
    // build time checks
    // ----------------------------------------------------------------
    initial
    begin
        if (CLK_MHZ < `LLDP_CLK_MHZ_MIN || CLK_MHZ > `LLDP_CLK_MHZ_MAX)
            $error("clock out of range");
        if (!lldp_group_ok(GROUP))
            $error("bad strobe group");
    end

    // ----------------------------------------------------------------
    // command path
    // ----------------------------------------------------------------
    lldp_cmd_t         cmd_q;
    logic [ADDR_W-1:0] addr_q;
    logic [`LLDP_BANK_W-1:0] bank_q;

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            cmd_q  <= `LLDP_CMD_IDLE;
            addr_q <= '0;
            bank_q <= '0;
        end
        else
        begin
            cmd_q  <= '{CTL_CS_N, CTL_WE_N, CTL_REF_N};
            addr_q <= CTL_ADDR;
            bank_q <= CTL_BANK;
        end
    end

    assign MEM_ADDR_0  = addr_q;
    assign MEM_BANK_0  = bank_q;
    assign MEM_CS_N_0  = cmd_q.cs_n;
    assign MEM_WE_N_0  = cmd_q.we_n;
    assign MEM_REF_N_0 = cmd_q.ref_n;

    // second bus mirrors the first; idle when not configured
    generate
        if (TWO_CMD != 0)
        begin : g_two
            assign MEM_ADDR_1  = addr_q;
            assign MEM_BANK_1  = bank_q;
            assign MEM_CS_N_1  = cmd_q.cs_n;
            assign MEM_WE_N_1  = cmd_q.we_n;
            assign MEM_REF_N_1 = cmd_q.ref_n;
        end
        else
        begin : g_one
            assign MEM_ADDR_1  = '0;
            assign MEM_BANK_1  = '0;
            assign MEM_CS_N_1  = 1'b1;
            assign MEM_WE_N_1  = 1'b1;
            assign MEM_REF_N_1 = 1'b1;
        end
    endgenerate

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    logic [2*DATA_W-1:0]  wdata_q;
    logic [2*DEVICES-1:0] wmask_q;
    logic                 wr_q;
    logic                 beat_q;

    // data held when valid is low; controller keeps valid aligned
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            wdata_q <= '0;
            wmask_q <= '0;
        end
        else if (CTL_WDATA_VALID)
        begin
            wdata_q <= CTL_WDATA;
            wmask_q <= CTL_WRITE_MASK;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            wr_q   <= 1'b0;
            beat_q <= 1'b0;
        end
        else
        begin
            wr_q   <= CTL_DOING_WR;
            beat_q <= CTL_DOING_WR ? ~beat_q : 1'b0;
        end
    end

    // next register contents, so beat 0 leaves together with the load
    logic [2*DATA_W-1:0]  wdata_d;
    logic [2*DEVICES-1:0] wmask_d;
    assign wdata_d = CTL_WDATA_VALID ? CTL_WDATA : wdata_q;
    assign wmask_d = CTL_WDATA_VALID ? CTL_WRITE_MASK : wmask_q;

    // low half goes out first, high half on the following cycle
    logic [DATA_W-1:0]  wbeat;
    logic [DEVICES-1:0] mbeat;
    always_comb
    begin
        wbeat = beat_q ? wdata_d[2*DATA_W-1:DATA_W] : wdata_d[DATA_W-1:0];
        for (int i = 0; i < DEVICES; i++)
            mbeat[i] = wmask_d[2*i + (beat_q ? 1 : 0)];
    end

    logic [DATA_W-1:0]  dout_q;
    logic [DEVICES-1:0] mout_q;
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            dout_q <= '0;
            mout_q <= '0;
        end
        else
        begin
            dout_q <= wbeat;
            mout_q <= mbeat;
        end
    end

    assign MEM_BYTE_MASK = mout_q;

    generate
        if (SPLIT_IO != 0)
        begin : g_sio
            assign MEM_D       = dout_q;
            assign MEM_D_OE_N  = ~wr_q;
            assign MEM_DQ_O    = '0;
            assign MEM_DQ_OE_N = '1;
        end
        else
        begin : g_cio
            assign MEM_DQ_O    = dout_q;
            assign MEM_DQ_OE_N = {DATA_W{~wr_q}};
            assign MEM_D       = '0;
            assign MEM_D_OE_N  = 1'b1;
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  rd_src;
    logic [STROBES-1:0] stb1_q, stb2_q;
    assign rd_src = (SPLIT_IO != 0) ? MEM_Q : MEM_DQ_I;

    always_ff @(posedge CLOCK)
    begin
        stb1_q <= MEM_RETURN_STROBE;
        stb2_q <= stb1_q;
    end

    genvar g;
    generate
        for (g = 0; g < DEVICES; g++)
        begin : g_dev
            lldp_capture #(
                .DEV_W (DEV_W),
                .GROUP (GROUP)
            ) u_cap (
                .clk         (CLOCK),
                .rst_n       (RSTN),
                .strobe_mode (STROBE_MODE),
                .strobe_sync (stb2_q[(g*DEV_W)/GROUP]),
                .pin_data    (rd_src[g*DEV_W +: DEV_W]),
                .pin_valid   (MEM_QVLD[g]),
                .rdata       (CTL_RDATA[2*g*DEV_W +: 2*DEV_W]),
                .rvalid      (CTL_QVLD[g])
            );
        end
    endgenerate

endmodule : lldp_datapath

//--- lldp_regs.svh
// lldp_regs.svh: timing and configuration constants for the datapath
// assumes: included by bare name from the package and the lldp_datapath module
`ifndef LLDP_REGS_SVH
`define LLDP_REGS_SVH

`define LLDP_CLK_MHZ_MIN   100
`define LLDP_CLK_MHZ_MAX   400
`define LLDP_CLK_MHZ_DEF   100
`define LLDP_BANK_W        3
`define LLDP_MASK_PER_DEV  2
`define LLDP_CMD_IDLE      3'h7

`endif

//--- lldp_pkg.sv
// lldp_pkg.sv: types for the low latency dram datapath
// assumes: lldp_regs.svh on the include path
package lldp_pkg;
`include "lldp_regs.svh"

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic ref_n;
    } lldp_cmd_t;

    typedef enum logic [1:0] {
        LLDP_IDLE  = 2'b01,
        LLDP_WRITE = 2'b10
    } lldp_wstate_t;

    // legal strobe group sizes
    function automatic logic lldp_group_ok(input int g);
        return (g == 8) || (g == 9) || (g == 16) || (g == 18);
    endfunction : lldp_group_ok

endpackage : lldp_pkg

//--- lldp_capture.sv
// lldp_capture.sv: read capture for one memory device
// assumes: data and valid arrive from pins, async to CLOCK
`timescale 1ns/1ns
module lldp_capture
    import lldp_pkg::*;
#(
    parameter int DEV_W = 18,
    parameter int GROUP = 9
)
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               strobe_mode,
    input  wire logic               strobe_sync,
    input  wire logic [DEV_W-1:0]   pin_data,
    input  wire logic               pin_valid,
    output logic      [2*DEV_W-1:0] rdata,
    output logic                    rvalid
);
    logic [DEV_W-1:0] d1_q, d2_q, lo_q;
    logic             v1_q, v2_q, half_q, strobe_q;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        d1_q <= pin_data;
        d2_q <= d1_q;
        v1_q <= pin_valid;
        v2_q <= v1_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            strobe_q <= 1'b0;
        else
            strobe_q <= strobe_sync;
    end

    // ----------------------------------------------------------------
    // beat pairing
    // ----------------------------------------------------------------
    // capture beat: strobe edge in strobe mode, every valid cycle else
    logic take;
    assign take = v2_q && (strobe_mode ? (strobe_sync != strobe_q)
                                       : 1'b1);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            half_q <= 1'b0;
            lo_q   <= '0;
            rdata  <= '0;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= 1'b0;
            if (!v2_q)
                half_q <= 1'b0;
            else if (take)
            begin
                if (!half_q)
                begin
                    lo_q   <= d2_q;
                    half_q <= 1'b1;
                end
                else
                begin
                    rdata  <= {d2_q, lo_q};
                    rvalid <= 1'b1;
                    half_q <= 1'b0;
                end
            end
        end
    end

    initial if (!lldp_group_ok(GROUP)) $error("bad group size");

endmodule : lldp_capture

//--- lldp_datapath_asserts.sv
// lldp_datapath_asserts.sv: port checks for the datapath
// assumes: bound to lldp_datapath, common-io build, one device
`timescale 1ns/1ns
module lldp_datapath_asserts #(
    parameter int DATA_W  = 18,
    parameter int ADDR_W  = 20,
    parameter int TWO_CMD = 0
)(
    input wire logic              CLOCK,
    input wire logic              RSTN,
    input wire logic              STROBE_MODE,
    input wire logic [ADDR_W-1:0] CTL_ADDR,
    input wire logic              CTL_CS_N,
    input wire logic              CTL_WE_N,
    input wire logic              CTL_REF_N,
    input wire logic              CTL_DOING_WR,
    input wire logic [2*DATA_W-1:0] CTL_WDATA,
    input wire logic              CTL_WDATA_VALID,
    input wire logic [1:0]        CTL_WRITE_MASK,
    input wire logic [0:0]        CTL_QVLD,
    input wire logic [ADDR_W-1:0] MEM_ADDR_0,
    input wire logic              MEM_CS_N_0,
    input wire logic              MEM_WE_N_0,
    input wire logic              MEM_REF_N_0,
    input wire logic [ADDR_W-1:0] MEM_ADDR_1,
    input wire logic              MEM_CS_N_1,
    input wire logic [DATA_W-1:0] MEM_DQ_O,
    input wire logic [DATA_W-1:0] MEM_DQ_OE_N,
    input wire logic [0:0]        MEM_QVLD,
    input wire logic [0:0]        MEM_BYTE_MASK
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    a_cmd_pins: assert property (
        $past(RSTN) |-> {MEM_CS_N_0, MEM_WE_N_0, MEM_REF_N_0}
        == $past({CTL_CS_N, CTL_WE_N, CTL_REF_N})) else $error("cmd pins");
    a_addr_pins: assert property (
        $past(RSTN) |-> MEM_ADDR_0 == $past(CTL_ADDR)) else $error("addr");
    a_second_bus: assert property (
        MEM_CS_N_1 == (TWO_CMD != 0 ? MEM_CS_N_0 : 1'b1)
        && MEM_ADDR_1 == (TWO_CMD != 0 ? MEM_ADDR_0 : '0))
        else $error("second bus");
    a_oe_follow: assert property (
        $past(RSTN) |-> MEM_DQ_OE_N == {DATA_W{!$past(CTL_DOING_WR)}})
        else $error("output enable");
    a_dq_first: assert property (
        CTL_WDATA_VALID && CTL_DOING_WR && !$past(CTL_DOING_WR)
        |=> MEM_DQ_O == $past(CTL_WDATA[DATA_W-1:0])) else $error("beat 0");
    a_dq_second: assert property (
        CTL_WDATA_VALID && CTL_DOING_WR && !$past(CTL_DOING_WR)
        ##1 CTL_DOING_WR |=> MEM_DQ_O == $past(CTL_WDATA[2*DATA_W-1:DATA_W], 2)
        && MEM_BYTE_MASK[0] == $past(CTL_WRITE_MASK[1], 2))
        else $error("beat 1");
    a_qvld_pulse: assert property (
        CTL_QVLD[0] |=> !CTL_QVLD[0]) else $error("qvld pulse");
    a_qvld_cause: assert property (
        CTL_QVLD[0] && !STROBE_MODE |-> $past(MEM_QVLD[0], 3)
        && $past(MEM_QVLD[0], 4)) else $error("qvld cause");
endmodule : lldp_datapath_asserts

bind lldp_datapath lldp_datapath_asserts #(
    .DATA_W(DATA_W), .ADDR_W(ADDR_W), .TWO_CMD(TWO_CMD)
) u_chk (.*);

//--- lldp_mem_model.sv
// lldp_mem_model.sv: memory side answering one read burst
// assumes: inputs change at falling clock edges
`timescale 1ns/1ns
module lldp_mem_model #(
    parameter int W = 18
)(
    input  wire logic       clk,
    output logic [W-1:0]    dq,
    output logic            qvld,
    output logic [1:0]      strobe
);
    initial
    begin
        dq = '0;
        qvld = 1'b0;
        strobe = 2'h0;
    end
    // two beats, strobe toggles per beat unless hushed
    task automatic send(input logic [2*W-1:0] w, input logic hush);
        @(negedge clk);
        qvld = 1'b1;
        dq = w[W-1:0];
        if (!hush) strobe = ~strobe;
        @(negedge clk);
        dq = w[2*W-1:W];
        if (!hush) strobe = ~strobe;
        @(negedge clk);
        qvld = 1'b0;
        dq = ~dq;
    endtask : send
endmodule : lldp_mem_model

//--- testbench.sv
// testbench.sv: directed tests of the datapath
// assumes: common-io build, one device, second command bus on
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import lldp_pkg::*;
    logic clk = 0, rstn = 0, smode = 0, doing = 0, wvalid = 0;
    lldp_cmd_t cmd = '1;
    logic [19:0] addr = '0, a0, a1;
    logic [2:0] bank = '0, b0, b1;
    logic [35:0] wdata = '0, rdata;
    logic [1:0] wmask = '0, strb;
    logic [17:0] dq_o, oe_n, dq_i, d_o;
    logic cs0, we0, rf0, cs1, we1, rf1, d_oe, qv, qvc, bm;
    int num_errors = 0, n_checks = 0;
    lldp_datapath #(.TWO_CMD(1)) i_dut (.CLOCK(clk), .RSTN(rstn),
        .STROBE_MODE(smode), .CTL_ADDR(addr), .CTL_BANK(bank),
        .CTL_CS_N(cmd.cs_n), .CTL_WE_N(cmd.we_n), .CTL_REF_N(cmd.ref_n),
        .CTL_DOING_WR(doing), .CTL_WDATA(wdata), .CTL_WDATA_VALID(wvalid),
        .CTL_WRITE_MASK(wmask), .CTL_RDATA(rdata), .CTL_QVLD(qvc),
        .MEM_ADDR_0(a0), .MEM_BANK_0(b0), .MEM_CS_N_0(cs0), .MEM_WE_N_0(we0),
        .MEM_REF_N_0(rf0), .MEM_ADDR_1(a1), .MEM_BANK_1(b1), .MEM_CS_N_1(cs1),
        .MEM_WE_N_1(we1), .MEM_REF_N_1(rf1), .MEM_DQ_O(dq_o),
        .MEM_DQ_OE_N(oe_n), .MEM_DQ_I(dq_i), .MEM_D(d_o), .MEM_D_OE_N(d_oe),
        .MEM_Q(dq_i),
        .MEM_RETURN_STROBE(strb), .MEM_QVLD(qv), .MEM_BYTE_MASK(bm));
    lldp_mem_model i_mem (.clk(clk), .dq(dq_i), .qvld(qv), .strobe(strb));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [35:0] w, input logic [1:0] m,
                      input logic v, input logic [35:0] ew,
                      input logic [1:0] em);
        @(negedge clk);
        {doing, wvalid, wdata, wmask} = {1'b1, v, w, m};
        tick();
        `CHK(oe_n, 18'h0)
        `CHK({d_oe, d_o}, {1'b1, 18'h0})
        `CHK(dq_o, ew[17:0])
        `CHK(bm, em[0])
        @(negedge clk);
        {wvalid, wdata, wmask} = {1'b0, ~w, ~m};
        tick();
        `CHK(dq_o, ew[35:18])
        `CHK(bm, em[1])
        @(negedge clk);
        doing = 0;
        tick();
        `CHK(oe_n, 18'h3FFFF)
    endtask : wr
    task automatic rd(input logic [35:0] w, input logic hush, input int exp);
        int seen;
        seen = 0;
        fork
            i_mem.send(w, hush);
            repeat (12)
            begin
                tick();
                if (qvc === 1'b1)
                begin
                    seen++;
                    `CHK(rdata, w)
                end
            end
        join
        `CHK(seen, exp)
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) tick();
        `CHK({cs0, we0, rf0, oe_n, qvc}, {3'h7, 18'h3FFFF, 1'b0})
        $display("test reset done");
        @(negedge clk);
        rstn = 1;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            cmd = i[2:0];
            addr = 20'hFFFFF ^ 20'(i * 20'h11111);
            bank = i[2:0];
            tick();
            `CHK({cs0, we0, rf0}, i[2:0])
            `CHK({a0, b0}, {addr, bank})
            `CHK({a1, b1, cs1, we1, rf1}, {addr, bank, cmd})
        end
        $display("test commands done");
        wr(36'hA5A5A5A5A, 2'h1, 1, 36'hA5A5A5A5A, 2'h1);
        wr(36'h123456789, 2'h2, 0, 36'hA5A5A5A5A, 2'h1);
        wr(36'h0F0F0F0F0, 2'h2, 1, 36'h0F0F0F0F0, 2'h2);
        $display("test writes done");
        rd(36'hC3C3C1234, 0, 1);
        rd(36'h3C3C3EDCB, 0, 1);
        $display("test reads done");
        @(negedge clk);
        smode = 1;
        rd(36'h555555555, 1, 0);
        rd(36'h9ABCDE123, 0, 1);
        $display("test strobe mode done");
        report_and_stop();
    end
endmodule : testbench
